/* include/chp_pkg.sv */
// package of constants for the card host pin mode block
// Functional notes
// - bus clock pin always driven as output
// - native mode command line is bidirectional
// - spi mode command line output only
// - native mode data line zero bidirectional
// - spi mode data line zero is input
// - native data line one: wide data, interrupt
// - spi data line one is interrupt input
// - data line two: native data, spi select zero
// - data line three: native data, spi select one
// - only software chosen protocol governs the bus
// - mmc protocol allows many cards on bus
// - sd protocol serves a single memory card
// - sdio protocol serves a single io card
// - spi mode addresses two cards via selects
// - single bit rate at most 19.5 Mbps
// - four bit rate at most 78 Mbps
package chp_pkg;
  // ****************************************
  // protocol selection
  // ****************************************
  typedef enum logic [1:0] {
    CHP_MMC  = 2'h0,
    CHP_SD   = 2'h1,
    CHP_SDIO = 2'h2,
    CHP_SPI  = 2'h3
  } chp_proto_t;

  // ****************************************
  // timing
  // ****************************************
  localparam int CLK_MHZ        = 250;
  localparam int RATE1_KBPS     = 19500;
  localparam int RATE4_KBPS     = 78000;
  // bits per line per second limit; four lines share 78 Mbps
  localparam int HALF1_CYC      = (CLK_MHZ * 1000 + 2 * RATE1_KBPS - 1) / (2 * RATE1_KBPS);
  localparam int HALF4_CYC      = (CLK_MHZ * 1000 * 4 + 2 * RATE4_KBPS - 1) / (2 * RATE4_KBPS);
  localparam int DIV_W          = 8;
  localparam logic [DIV_W-1:0] DIV_RST = 8'h00;
endpackage : chp_pkg

/* rtl/chp_sync.sv */
// two flop synchroniser for a pin input
`timescale 1ns/1ps
module chp_sync
  import chp_pkg::*;
(
  // clock and reset
  input  wire logic clk,
  input  wire logic rst_n,
  input  wire logic ce,
  // data
  input  wire logic d,
  output logic      q
);
  logic meta_q;
  logic meta_d;
  logic q_d;

  always_comb begin
    meta_d = ce ? d : meta_q;
    q_d    = ce ? meta_q : q;
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      // pins idle high on their pull-ups; avoids a false low after reset
      meta_q <= 1'b1;
      q      <= 1'b1;
    end else begin
      meta_q <= meta_d;
      q      <= q_d;
    end
  end
endmodule : chp_sync

/* rtl/chp_clkdiv.sv */
// divider making the card bus clock from the core clock
`timescale 1ns/1ps
module chp_clkdiv
  import chp_pkg::*;
(
  // clock and reset
  input  wire logic             clk,
  input  wire logic             rst_n,
  input  wire logic             ce,
  // control
  input  wire logic             run,
  input  wire logic [DIV_W-1:0] half,
  // outputs
  output logic                  sclk_q,
  output logic                  rise_q,
  output logic                  fall_q
);
  logic [DIV_W-1:0] cnt_q;
  logic [DIV_W-1:0] cnt_d;
  logic             sclk_d;
  logic             rise_d;
  logic             fall_d;

  always_comb begin
    cnt_d  = cnt_q;
    sclk_d = sclk_q;
    rise_d = 1'b0;
    fall_d = 1'b0;
    if (!run) begin
      cnt_d  = DIV_RST;
      sclk_d = 1'b0;
    end else if (cnt_q >= half - 8'h01) begin
      cnt_d  = DIV_RST;
      sclk_d = ~sclk_q;
      rise_d = ~sclk_q;
      fall_d = sclk_q;
    end else begin
      cnt_d = cnt_q + 8'h01;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt_q  <= DIV_RST;
      sclk_q <= 1'b0;
      rise_q <= 1'b0;
      fall_q <= 1'b0;
    end else if (ce) begin
      cnt_q  <= cnt_d;
      sclk_q <= sclk_d;
      rise_q <= rise_d;
      fall_q <= fall_d;
    end
  end
endmodule : chp_clkdiv

/* rtl/chp_pins.sv */
// pin mode steering for the card host controller
`timescale 1ns/1ps
module chp_pins
  import chp_pkg::*;
(
  // clock and reset
  input  wire logic       clk,
  input  wire logic       rst_n,
  input  wire logic       ce,
  // mode and control from the command engine
  input  wire chp_proto_t proto,
  input  wire logic       wide,
  input  wire logic       bus_run,
  input  wire logic       spi_sel,
  input  wire logic       spi_act,
  input  wire logic       cmd_oe,
  input  wire logic       cmd_out,
  input  wire logic       dat_oe,
  input  wire logic [3:0] dat_out,
  // values seen on the pins, synchronised, and bus clock edge pulses
  output logic            cmd_in_q,
  output logic [3:0]      dat_in_q,
  output logic            sdio_irq_q,
  output logic            bit_rise_q,
  output logic            bit_fall_q,
  // card pins
  output logic            card_bus_clock_q,
  input  wire logic       card_command_line_i,
  output logic            card_command_line_o_q,
  output logic            card_command_line_oe_q,
  input  wire logic [3:0] card_data_line_i,
  output logic [3:0]      card_data_line_o_q,
  output logic [3:0]      card_data_line_oe_q
);
  // ****************************************
  // pin input synchronisers
  // ****************************************
  logic       cmd_s;
  logic [3:0] dat_s;

  chp_sync u_cmd_sync (
    .clk   (clk),
    .rst_n (rst_n),
    .ce    (ce),
    .d     (card_command_line_i),
    .q     (cmd_s)
  );

  genvar gi;
  generate
    for (gi = 0; gi < 4; gi++) begin : g_dat_sync
      chp_sync u_dat_sync (
        .clk   (clk),
        .rst_n (rst_n),
        .ce    (ce),
        .d     (card_data_line_i[gi]),
        .q     (dat_s[gi])
      );
    end
  endgenerate

  // ****************************************
  // bus clock divider
  // ****************************************
  logic             spi_mode;
  logic             four_bit;
  logic [DIV_W-1:0] half;
  logic             sclk;
  logic             rise;
  logic             fall;

  assign spi_mode = (proto == CHP_SPI);
  // only sd and sdio may run four lines wide
  assign four_bit = wide && ((proto == CHP_SD) || (proto == CHP_SDIO));
  assign half     = four_bit ? DIV_W'(HALF4_CYC) : DIV_W'(HALF1_CYC);

  chp_clkdiv u_div (
    .clk    (clk),
    .rst_n  (rst_n),
    .ce     (ce),
    .run    (bus_run),
    .half   (half),
    .sclk_q (sclk),
    .rise_q (rise),
    .fall_q (fall)
  );

  // ****************************************
  // pin direction and role
  // ****************************************
  logic       clk_d;
  logic       cmd_o_d;
  logic       cmd_oe_d;
  logic [3:0] dat_o_d;
  logic [3:0] dat_oe_d;
  logic       irq_d;

  always_comb begin
    clk_d    = sclk;
    cmd_o_d  = cmd_out;
    dat_o_d  = 4'h0;
    dat_oe_d = 4'h0;
    irq_d    = 1'b0;
    if (spi_mode) begin
      cmd_oe_d    = 1'b1;
      cmd_o_d     = spi_act ? cmd_out : 1'b1;
      dat_oe_d    = 4'hC;
      // selects are active low; only one asserted at once
      dat_o_d[2]  = ~(spi_act && !spi_sel);
      dat_o_d[3]  = ~(spi_act && spi_sel);
      irq_d       = ~dat_s[1];
    end else begin
      cmd_oe_d = cmd_oe;
      if (dat_oe) begin
        dat_oe_d = four_bit ? 4'hF : 4'h1;
        dat_o_d  = four_bit ? dat_out : {3'h0, dat_out[0]};
      end
      // sdio interrupt on line one while the host is not driving data (dat_oe low)
      irq_d = (proto == CHP_SDIO) && !dat_oe && !dat_s[1];
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      card_bus_clock_q       <= 1'b0;
      card_command_line_o_q  <= 1'b1;
      card_command_line_oe_q <= 1'b0;
      card_data_line_o_q     <= 4'h0;
      card_data_line_oe_q    <= 4'h0;
      cmd_in_q               <= 1'b1;
      dat_in_q               <= 4'hF;
      sdio_irq_q             <= 1'b0;
      bit_rise_q             <= 1'b0;
      bit_fall_q             <= 1'b0;
    end else if (ce) begin
      card_bus_clock_q       <= clk_d;
      card_command_line_o_q  <= cmd_o_d;
      card_command_line_oe_q <= cmd_oe_d;
      card_data_line_o_q     <= dat_o_d;
      card_data_line_oe_q    <= dat_oe_d;
      cmd_in_q               <= cmd_s;
      dat_in_q               <= dat_s;
      sdio_irq_q             <= irq_d;
      bit_rise_q             <= rise;
      bit_fall_q             <= fall;
    end
  end

  // ****************************************
  // checks
  // ****************************************
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  clock_out_a: assert property (1'b1 |=> $past(sclk) == card_bus_clock_q || !$past(ce))
    else $error("bus clock pin not following divider");
  spi_cmd_out_a: assert property (spi_mode && ce |=> card_command_line_oe_q)
    else $error("spi command line not driven");
  spi_dat0_in_a: assert property (spi_mode && ce |=> !card_data_line_oe_q[0] && !card_data_line_oe_q[1])
    else $error("spi data line zero or one driven");
  spi_sel_drv_a: assert property (spi_mode && ce |=> card_data_line_oe_q[3:2] == 2'h3)
    else $error("spi selects not driven");
  one_select_a: assert property (card_data_line_oe_q[3:2] == 2'h3 |-> card_data_line_o_q[3] || card_data_line_o_q[2])
    else $error("both spi selects asserted");
  nat_cmd_dir_a: assert property (!spi_mode && ce |=> card_command_line_oe_q == $past(cmd_oe))
    else $error("native command direction wrong");
  mmc_narrow_a: assert property (proto == CHP_MMC && ce |=> card_data_line_oe_q[3:1] == 3'h0)
    else $error("mmc drives wide lines");
  wide_drv_a: assert property (four_bit && dat_oe && !spi_mode && ce |=> card_data_line_oe_q == 4'hF)
    else $error("wide transfer not on four lines");
  native_dat0_a: assert property (!spi_mode && dat_oe && ce |=> card_data_line_oe_q[0])
    else $error("native data line zero not driven");
  rate_half_a: assert property (u_div.cnt_q < half || !bus_run)
    else $error("divider exceeds half period");
endmodule : chp_pins

/* dv/chp_card.sv */
// card side model: resolves pins with pull-ups and card drivers
`timescale 1ns/1ps
module chp_card
(
  // controller pins
  input  wire logic       cmd_o,
  input  wire logic       cmd_oe,
  input  wire logic [3:0] dat_o,
  input  wire logic [3:0] dat_oe,
  // card drive
  input  wire logic       c_en,
  input  wire logic [3:0] d_en,
  input  wire logic [3:0] d_val,
  // resolved lines
  output logic            cmd_w,
  output logic [3:0]      dat_w
);
  // released lines go to the pull-up level
  assign cmd_w = cmd_oe ? cmd_o : (c_en ? 1'h0 : 1'h1);
  always_comb begin
    for (int i = 0; i < 4; i++) begin
      dat_w[i] = dat_oe[i] ? dat_o[i] : (d_en[i] ? d_val[i] : 1'h1);
    end
  end
endmodule : chp_card

/* dv/card_host_pin_modes_test.sv */
// self-checking bench for the pin mode block
`timescale 1ns/1ps
module card_host_pin_modes_test
  import chp_pkg::*;
;
  // ****************************************
  // signals
  // ****************************************
  typedef struct packed {logic [6:0] in; logic eco; logic [3:0] edo; logic [1:0] esel;} chp_row_t;
  logic       clk = 1'h0, rst_n = 1'h0, wide = 1'h0, bus_run = 1'h0, spi_sel = 1'h0, spi_act = 1'h0;
  logic       cmd_oe = 1'h0, dat_oe = 1'h0, c_en = 1'h0, co_q, coe_q, ci_q, irq_q, bclk;
  logic [3:0] d_en = 4'h0, d_val = 4'hF, dat_in_q, do_q, doe_q, dat_w;
  logic       cmd_w;
  logic [7:0] n, nr = 8'h00, nf = 8'h00;
  logic       br, bf;
  chp_proto_t proto = CHP_MMC;
  int         error_cnt = 0, total_checks = 0, cyc = 0;
  chp_row_t   rows[7] = '{'{7'h13, 1'h1, 4'h1, 2'h3}, '{7'h33, 1'h1, 4'hF, 2'h3}, '{7'h43, 1'h1, 4'h1, 2'h3},
                          '{7'h50, 1'h0, 4'h0, 2'h3}, '{7'h69, 1'h1, 4'hC, 2'h2}, '{7'h6C, 1'h1, 4'hC, 2'h1},
                          '{7'h71, 1'h1, 4'hC, 2'h3}};
  chp_pins dut (.clk(clk), .rst_n(rst_n), .ce(1'h1), .proto(proto), .wide(wide), .bus_run(bus_run),
    .spi_sel(spi_sel), .spi_act(spi_act), .cmd_oe(cmd_oe), .cmd_out(1'h0), .dat_oe(dat_oe), .dat_out(4'hA),
    .cmd_in_q(ci_q), .dat_in_q(dat_in_q), .sdio_irq_q(irq_q), .bit_rise_q(br), .bit_fall_q(bf),
    .card_bus_clock_q(bclk), .card_command_line_i(cmd_w), .card_command_line_o_q(co_q),
    .card_command_line_oe_q(coe_q), .card_data_line_i(dat_w), .card_data_line_o_q(do_q),
    .card_data_line_oe_q(doe_q));
  chp_card card (.cmd_o(co_q), .cmd_oe(coe_q), .dat_o(do_q), .dat_oe(doe_q), .c_en(c_en), .d_en(d_en),
    .d_val(d_val), .cmd_w(cmd_w), .dat_w(dat_w));
  // ****************************************
  // tasks
  // ****************************************
  task automatic chk(input logic [7:0] s, input logic [7:0] e, input string m);
    total_checks++;
    if (s !== e) begin
      error_cnt++;
      $display("MISMATCH %0t %s", $time, m);
    end
  endtask : chk
  task automatic results();
    $display("checks %0d errors %0d", total_checks, error_cnt);
    if (error_cnt == 0 && total_checks > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask : results
  task automatic hi_len(output logic [7:0] k);
    wait (bclk === 1'h0);
    wait (bclk === 1'h1);
    k = 8'h00;
    do begin
      @(posedge clk);
      #1;
      k++;
    end while (bclk === 1'h1 && k < 8'hFF);
  endtask : hi_len
  initial forever #2 clk = ~clk;
  // count divider edge pulses
  always @(posedge clk) begin
    nr <= nr + {7'h00, br};
    nf <= nf + {7'h00, bf};
  end
  always @(posedge clk) begin
    cyc++;
    if (cyc == 4000) begin
      error_cnt++;
      results();
    end
  end
  // ****************************************
  // tests
  // ****************************************
  initial begin
    repeat (8) @(posedge clk);
    #1;
    chk(coe_q, 1'h0, "reset cmd oe");
    chk(co_q, 1'h1, "reset cmd o");
    rst_n <= 1'h1;
    foreach (rows[i]) begin
      @(posedge clk);
      {proto, wide, spi_act, spi_sel, cmd_oe, dat_oe} <= rows[i].in;
      repeat (2) @(posedge clk);
      #1;
      chk(coe_q, rows[i].eco, "cmd oe");
      chk(doe_q, rows[i].edo, "data oe");
      if (proto == CHP_SPI) begin
        chk(do_q[3:2], rows[i].esel, "select");
        chk(co_q, !rows[i].in[3], "cmd level");
      end
    end
    $display("pin table done");
    @(posedge clk);
    {proto, wide, spi_act, cmd_oe, dat_oe, c_en, d_en, d_val} <= {CHP_SDIO, 5'h01, 4'hF, 4'h4};
    repeat (6) @(posedge clk);
    #1;
    chk(ci_q, 1'h0, "response in");
    chk(dat_in_q, 4'h4, "read data");
    chk(irq_q, 1'h1, "native irq");
    proto <= CHP_SPI;
    repeat (6) @(posedge clk);
    #1;
    chk(dat_in_q, 4'hC, "spi inputs");
    chk(irq_q, 1'h1, "spi irq");
    {proto, dat_oe} <= {CHP_SD, 1'h1};
    repeat (6) @(posedge clk);
    #1;
    chk(irq_q, 1'h0, "sd no irq");
    $display("input test done");
    {proto, bus_run, wide} <= {CHP_MMC, 2'h3};
    hi_len(n);
    chk(n, HALF1_CYC[7:0], "half period 1");
    proto <= CHP_SD;
    repeat (20) @(posedge clk);
    hi_len(n);
    chk(n, HALF4_CYC[7:0], "half period 4");
    bus_run <= 1'h0;
    repeat (20) @(posedge clk);
    #1;
    chk(bclk, 1'h0, "clock stopped");
    chk(nr > 8'h00 && (nr == nf || nr == nf + 8'h01), 1'h1, "edge pulses");
    $display("clock test done");
    rst_n <= 1'h0;
    @(posedge clk);
    #1;
    chk(doe_q, 4'h0, "mid reset oe");
    chk(ci_q, 1'h1, "mid reset in");
    $display("reset test done");
    results();
  end
endmodule : card_host_pin_modes_test
